// ---- src/eds_pkg.sv ----
// constants, types and register map of the event step sequencer
package eds_pkg;
  localparam int STEPS = 16;
  localparam int OUTS = 16;
  localparam int CLK_PERIOD_PS = 5000;
  localparam longint HUNDREDTH_PS = 64'd10_000_000_000;
  localparam int TICK_CYCLES = int'(HUNDREDTH_PS / CLK_PERIOD_PS);
  localparam logic [13:0] SETTING_MAX = 14'd9999;
  // register byte offsets
  localparam logic [7:0] OFS_TIMEBASE = 8'h00;
  localparam logic [7:0] OFS_LAST_STEP = 8'h04;
  localparam logic [7:0] OFS_OUT_MASK = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_STEP_COUNT = 8'h10;
  localparam logic [7:0] OFS_TICK_TIMER = 8'h14;
  localparam logic [7:0] OFS_PRESET_STEP = 8'h18;
  localparam logic [7:0] OFS_CURRENT_STEP = 8'h1C;
  localparam logic [7:0] OFS_PATTERN_BASE = 8'h40;
  localparam logic [7:0] OFS_LIMIT_BASE = 8'h80;
  localparam logic [7:0] OFS_EVCFG_BASE = 8'hC0;
  // reset values
  localparam logic [13:0] RST_TIMEBASE = 14'h0001;
  localparam logic [4:0] RST_LAST_STEP = 5'h10;
  localparam logic [15:0] RST_OUT_MASK = 16'hFFFF;
  localparam logic [4:0] RST_PRESET_STEP = 5'h01;
  localparam logic [15:0] RST_PATTERN = 16'h0000;
  localparam logic [13:0] RST_LIMIT = 14'h0000;
  // event config field positions
  localparam int EVCFG_MODE_LSB = 0;
  localparam int EVCFG_SRC_LSB = 2;
  localparam int EVCFG_BIT_LSB = 4;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_BOTH = 2'h2
  } eds_mode_e;

  typedef enum logic [1:0] {
    SRC_INPUT = 2'h0,
    SRC_OUTPUT = 2'h1,
    SRC_RELAY = 2'h2
  } eds_src_e;

  typedef struct packed {
    logic [3:0] bit_sel;
    eds_src_e src;
    eds_mode_e mode;
  } eds_evcfg_s;

  // gray along run -> complete -> held
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DONE = 2'b01,
    ST_HELD = 2'b11
  } eds_state_e;
endpackage : eds_pkg

// ---- src/eds_sequencer.sv ----
// event step sequencer with avalon-mm register slave
//
// Overview of operation
// - sixteen steps, each holding an on/off state for sixteen outputs
// - steps numbered 1..16, outputs 0..15 matching word bit positions
// - all steps share outputs; each step has its own pattern
// - timebase selectable from 0.01 s up to 99.99 s
// - one shared timebase, a separate count limit per step
// - dwell equals 0.01 s times timebase times step count
// - timebase and step counts accept values up to 9999
// - expired counts move to next step, outputs change at once
// - state evaluated once per scan tick only; a current step write here jumps off scan
// - timer-and-event step: timer runs only while event is true
// - each step is timer-only, event-only or both, mixed freely
// - step event chosen from input, output or relay points
// - partial use of steps and outputs is allowed
// - four consecutive progress words: count, timer, preset, step
// - complete bit set at cycle end, cleared on reset
// - first word holds count in step, fourth the current step
// - second word holds elapsed time in 0.01 s units
// - preset word changes only when software writes it
// - while reset is active the sequencer sits at the preset step
// - preset lets the sequencer jump directly to any step
// - reset beats start; start on runs, start off freezes
// - with reset off each jog rising edge advances one step
// - after last step: complete, keep pattern, ignore start and jog
// - start off halts in current step keeping outputs
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module eds_sequencer #(
  parameter int TICK_CYCLES = eds_pkg::TICK_CYCLES
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // scan-driven control
  input wire logic scan_tick_i,
  input wire logic start_i,
  input wire logic jog_i,
  input wire logic seq_reset_i,
  input wire logic [15:0] input_points_i,
  input wire logic [15:0] relay_points_i,
  output logic [15:0] pattern_o,
  output logic complete_o
);
  import eds_pkg::*;

  // step table; memories live here
  logic [15:0] pattern_mem [STEPS];
  logic [13:0] limit_mem [STEPS];
  eds_evcfg_s evcfg_mem [STEPS];

  logic [13:0] timebase;
  logic [4:0] last_step;
  logic [15:0] out_mask;
  logic [4:0] preset_step;
  logic [4:0] cur_step;
  logic [15:0] step_count;
  logic [15:0] tick_timer;
  eds_state_e state;
  logic jog_prev;
  logic [15:0] pend_ticks;
  logic [31:0] tick_div;
  logic bus_ack;
  logic [31:0] next_rdata;
  logic wr_go;
  logic [3:0] widx;
  logic [13:0] wset;

  assign wr_go = avs_write_i & bus_ack & ce_i;
  assign widx = avs_address_i[5:2];
  // settings whose low 16 bits exceed the largest legal value clamp to it
  assign wset = (avs_writedata_i[15:0] > 16'(SETTING_MAX)) ? SETTING_MAX :
                avs_writedata_i[13:0];

  // one wait state per access; readdata is captured beforehand
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~bus_ack;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      bus_ack <= 1'b0;
    end else if (ce_i) begin
      bus_ack <= (avs_read_i | avs_write_i) & ~bus_ack;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (avs_address_i == OFS_TIMEBASE) begin
      next_rdata = {18'h00000, timebase};
    end else if (avs_address_i == OFS_LAST_STEP) begin
      next_rdata = {27'h0000000, last_step};
    end else if (avs_address_i == OFS_OUT_MASK) begin
      next_rdata = {16'h0000, out_mask};
    end else if (avs_address_i == OFS_STATUS) begin
      next_rdata = {30'h00000000, state == ST_HELD, complete_o};
    end else if (avs_address_i == OFS_STEP_COUNT) begin
      next_rdata = {16'h0000, step_count};
    end else if (avs_address_i == OFS_TICK_TIMER) begin
      next_rdata = {16'h0000, tick_timer};
    end else if (avs_address_i == OFS_PRESET_STEP) begin
      next_rdata = {27'h0000000, preset_step};
    end else if (avs_address_i == OFS_CURRENT_STEP) begin
      next_rdata = {27'h0000000, cur_step};
    end else if (avs_address_i[7:6] == OFS_PATTERN_BASE[7:6]) begin
      next_rdata = {16'h0000, pattern_mem[widx]};
    end else if (avs_address_i[7:6] == OFS_LIMIT_BASE[7:6]) begin
      next_rdata = {18'h00000, limit_mem[widx]};
    end else if (avs_address_i[7:6] == OFS_EVCFG_BASE[7:6]) begin
      next_rdata = {24'h000000, evcfg_mem[widx]};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i && avs_read_i && !bus_ack) begin
      avs_readdata_o <= next_rdata;
    end
  end

  // global configuration registers
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      timebase <= RST_TIMEBASE;
      last_step <= RST_LAST_STEP;
      out_mask <= RST_OUT_MASK;
      preset_step <= RST_PRESET_STEP;
    end else if (wr_go) begin
      if (avs_address_i == OFS_TIMEBASE) begin
        // zero would count on every scan; 0.01 s is the floor
        timebase <= (wset == 14'h0000) ? 14'h0001 : wset;
      end else if (avs_address_i == OFS_LAST_STEP) begin
        if (avs_writedata_i[4:0] != 5'h00 && avs_writedata_i[4:0] <= 5'h10) begin
          last_step <= avs_writedata_i[4:0];
        end
      end else if (avs_address_i == OFS_OUT_MASK) begin
        out_mask <= avs_writedata_i[15:0];
      end else if (avs_address_i == OFS_PRESET_STEP) begin
        if (avs_writedata_i[4:0] != 5'h00 && avs_writedata_i[4:0] <= 5'h10) begin
          preset_step <= avs_writedata_i[4:0];
        end
      end
    end
  end

  // per-step table writes
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      for (int i = 0; i < STEPS; i++) begin
        pattern_mem[i] <= RST_PATTERN;
        limit_mem[i] <= RST_LIMIT;
        evcfg_mem[i] <= '0;
      end
    end else if (wr_go) begin
      if (avs_address_i[7:6] == OFS_PATTERN_BASE[7:6]) begin
        pattern_mem[widx] <= avs_writedata_i[15:0];
      end else if (avs_address_i[7:6] == OFS_LIMIT_BASE[7:6]) begin
        limit_mem[widx] <= wset;
      end else if (avs_address_i[7:6] == OFS_EVCFG_BASE[7:6]) begin
        evcfg_mem[widx] <= avs_writedata_i[7:0];
      end
    end
  end

  // 0.01 s tick generator and pending tick tally between scans
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tick_div <= 32'h0000_0000;
    end else if (ce_i) begin
      if (tick_div >= 32'(TICK_CYCLES - 1)) begin
        tick_div <= 32'h0000_0000;
      end else begin
        tick_div <= tick_div + 32'h0000_0001;
      end
    end
  end

  logic tick_now;
  assign tick_now = (tick_div >= 32'(TICK_CYCLES - 1));

  // a tick in the scan cycle itself survives the consume
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pend_ticks <= 16'h0000;
    end else if (ce_i) begin
      if (scan_tick_i) begin
        pend_ticks <= {15'h0000, tick_now};
      end else if (tick_now && pend_ticks != 16'hFFFF) begin
        pend_ticks <= pend_ticks + 16'h0001;
      end
    end
  end

  // current step's settings and chosen event point
  logic [3:0] cidx;
  eds_evcfg_s ccfg;
  logic ev_true;
  logic timer_on;
  logic [16:0] t_sum;
  logic cnt_step;
  logic [15:0] cnt_next;
  logic expire;
  logic jog_rise;

  assign cidx = 4'(cur_step - 5'h01);
  assign ccfg = evcfg_mem[cidx];

  always_comb begin
    ev_true = 1'b0;
    case (ccfg.src)
      SRC_INPUT: ev_true = input_points_i[ccfg.bit_sel];
      SRC_OUTPUT: ev_true = pattern_o[ccfg.bit_sel];
      SRC_RELAY: ev_true = relay_points_i[ccfg.bit_sel];
      default: ev_true = 1'b0;
    endcase
  end

  // timer only runs in timed modes, gated by the event when both
  assign timer_on = (ccfg.mode == MODE_TIMER) ||
                    (ccfg.mode == MODE_BOTH && ev_true);
  assign t_sum = {1'b0, tick_timer} + {1'b0, pend_ticks};
  assign cnt_step = t_sum >= {3'h0, timebase};
  assign cnt_next = step_count + {15'h0000, cnt_step};
  // dwell = 0.01 s * timebase * limit
  assign expire = timer_on && (cnt_next >= {2'h0, limit_mem[cidx]}) ||
                  (ccfg.mode == MODE_EVENT && ev_true);
  assign jog_rise = jog_i & ~jog_prev;

  // sequencer state, evaluated once per scan tick; current step writes apply at once
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= ST_RUN;
      cur_step <= RST_PRESET_STEP;
      step_count <= 16'h0000;
      tick_timer <= 16'h0000;
      complete_o <= 1'b0;
      jog_prev <= 1'b0;
    end else if (ce_i) begin
      if (wr_go && avs_address_i == OFS_CURRENT_STEP &&
          avs_writedata_i[4:0] != 5'h00 && avs_writedata_i[4:0] <= 5'h10) begin
        cur_step <= avs_writedata_i[4:0];
        step_count <= 16'h0000;
        tick_timer <= 16'h0000;
        if (state == ST_DONE) begin
          state <= ST_RUN;
          complete_o <= 1'b0;
        end
      end else if (scan_tick_i) begin
        jog_prev <= jog_i;
        if (seq_reset_i) begin
          // held at preset; the step does not run
          state <= ST_HELD;
          cur_step <= preset_step;
          complete_o <= 1'b0;
          step_count <= 16'h0000;
          tick_timer <= 16'h0000;
        end else if (state == ST_DONE) begin
          state <= ST_DONE;
        end else if (jog_rise) begin
          step_count <= 16'h0000;
          tick_timer <= 16'h0000;
          state <= ST_RUN;
          if (cur_step >= last_step) begin
            state <= ST_DONE;
            complete_o <= 1'b1;
          end else begin
            cur_step <= cur_step + 5'h01;
          end
        end else if (!start_i) begin
          state <= ST_RUN; // frozen, outputs held
        end else begin
          state <= ST_RUN;
          if (expire) begin
            step_count <= 16'h0000;
            tick_timer <= 16'h0000;
            if (cur_step >= last_step) begin
              state <= ST_DONE;
              complete_o <= 1'b1;
            end else begin
              cur_step <= cur_step + 5'h01;
            end
          end else if (timer_on) begin
            step_count <= cnt_next;
            tick_timer <= cnt_step ? 16'h0000 : t_sum[15:0];
          end
        end
      end
    end
  end

  // outputs follow the current step one cycle later; masked outputs stay off
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pattern_o <= 16'h0000;
    end else if (ce_i) begin
      pattern_o <= pattern_mem[cidx] & out_mask;
    end
  end
endmodule : eds_sequencer

// ---- sim/eds_sequencer_sva.sv ----
// port-level assertions for the event step sequencer
`timescale 1ns/1ps
module eds_sequencer_sva #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic scan_tick_i,
  input wire logic start_i,
  input wire logic jog_i,
  input wire logic seq_reset_i,
  input wire logic [15:0] input_points_i,
  input wire logic [15:0] relay_points_i,
  input wire logic [15:0] pattern_o,
  input wire logic complete_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // a scan evaluation that sees the sequencer reset
  wire rst_scan = scan_tick_i & ce_i & seq_reset_i;
  property p_wait1;
    (avs_read_i | avs_write_i) && avs_waitrequest_o && ce_i
      |=> !avs_waitrequest_o;
  endproperty
  a_wait1: assert property (p_wait1) else $error("wait state too long");
  property p_idle;
    !(avs_read_i | avs_write_i) |-> !avs_waitrequest_o;
  endproperty
  a_idle: assert property (p_idle) else $error("wait with no request");
  property p_rd_hold;
    !avs_read_i |=> $stable(avs_readdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_ce;
    !ce_i |=> $stable(pattern_o) && $stable(complete_o);
  endproperty
  a_ce: assert property (p_ce) else $error("state moved with ce low");
  property p_pat;
    !scan_tick_i && !avs_write_i ##1 !scan_tick_i && !avs_write_i
      |=> $stable(pattern_o);
  endproperty
  a_pat: assert property (p_pat) else $error("pattern moved off scan");
  property p_done_set;
    $rose(complete_o) |-> $past(scan_tick_i && ce_i);
  endproperty
  a_done_set: assert property (p_done_set) else $error("complete off scan");
  property p_done_hold;
    complete_o && !rst_scan && !avs_write_i |=> complete_o;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("complete lost");
  property p_done_clr;
    rst_scan |=> !complete_o;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("complete kept");
  c_done: cover property ($rose(complete_o));
  c_rd: cover property (avs_read_i && !avs_waitrequest_o);
  c_rst: cover property (rst_scan && complete_o);
endmodule : eds_sequencer_sva
bind eds_sequencer eds_sequencer_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .scan_tick_i(scan_tick_i), .start_i(start_i), .jog_i(jog_i),
  .seq_reset_i(seq_reset_i), .input_points_i(input_points_i),
  .relay_points_i(relay_points_i), .pattern_o(pattern_o),
  .complete_o(complete_o));

// ---- sim/eds_scan_ctl.sv ----
// control program model: scan pulse plus start, jog and reset levels
`timescale 1ns/1ps
module eds_scan_ctl #(
  parameter int SCAN_CYCLES = 8
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [2:0] req_i,
  output logic scan_tick_o,
  output logic start_o,
  output logic jog_o,
  output logic seq_reset_o
);
  logic [7:0] cnt;
  // levels change only on a scan, as a program updates once per scan
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt <= 8'h00;
      scan_tick_o <= 1'b0;
      {start_o, jog_o, seq_reset_o} <= 3'h0;
    end else begin
      cnt <= (cnt == 8'(SCAN_CYCLES - 1)) ? 8'h00 : cnt + 8'h01;
      scan_tick_o <= (cnt == 8'(SCAN_CYCLES - 1));
      if (scan_tick_o) {start_o, jog_o, seq_reset_o} <= req_i;
    end
  end
endmodule : eds_scan_ctl

// ---- sim/eds_sequencer_tb.sv ----
// self-checking bench for the event step sequencer
`timescale 1ns/1ps
module eds_sequencer_tb;
  import eds_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, v;
  logic wait_r, tick, start, jog, sreset, done;
  logic [2:0] req = 3'h0;
  logic [15:0] inpts = 16'h0000;
  logic [15:0] rly = 16'h0000;
  logic [15:0] pat;
  logic [7:0] ra [6] = '{OFS_TIMEBASE, OFS_LAST_STEP, OFS_OUT_MASK,
    OFS_PRESET_STEP, OFS_CURRENT_STEP, 8'h30};
  logic [31:0] re [6] = '{32'(RST_TIMEBASE), 32'(RST_LAST_STEP),
    32'(RST_OUT_MASK), 32'(RST_PRESET_STEP), 32'(RST_PRESET_STEP), 32'h0};
  int error_cnt = 0;
  int compares = 0;
  always #2.5 mclk_i = ~mclk_i;
  eds_sequencer #(.TICK_CYCLES(4)) dut (.mclk_i(mclk_i), .srst_i(srst_i),
    .ce_i(ce_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_r), .scan_tick_i(tick), .start_i(start),
    .jog_i(jog), .seq_reset_i(sreset), .input_points_i(inpts),
    .relay_points_i(rly), .pattern_o(pat), .complete_o(done));
  eds_scan_ctl ctl (.mclk_i(mclk_i), .srst_i(srst_i), .req_i(req),
    .scan_tick_o(tick), .start_o(start), .jog_o(jog), .seq_reset_o(sreset));
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // held until waitrequest is seen low, then released
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    @(posedge mclk_i);
    while (wait_r !== 1'b0) @(posedge mclk_i);
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk_i);
  endtask : xfer
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, v);
  endtask : rdchk
  // let n scans pass, then two cycles for the lagging pattern
  task automatic scans(input int n);
    repeat (n) @(posedge mclk_i iff tick);
    repeat (2) @(posedge mclk_i);
  endtask : scans
  task automatic close_out();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  // watchdog well beyond the roughly thirty scans the tests need
  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    srst_i <= 1'b0;
    foreach (ra[i]) rdchk(ra[i], re[i]);
    ce_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    ce_i <= 1'b1;
    $display("test reset done");
    xfer(1'b1, OFS_PATTERN_BASE, 32'hA5A5);
    xfer(1'b1, OFS_PATTERN_BASE + 8'h04, 32'h5A5A);
    xfer(1'b1, OFS_LIMIT_BASE, 32'h2);
    xfer(1'b1, OFS_LIMIT_BASE + 8'h04, 32'd12000);
    rdchk(OFS_LIMIT_BASE + 8'h04, 32'd9999);
    xfer(1'b1, OFS_TIMEBASE, 32'h0);
    rdchk(OFS_TIMEBASE, 32'h1);
    chk("pattern", 32'hA5A5, {16'h0, pat});
    req <= 3'b100;
    scans(3);
    rdchk(OFS_STEP_COUNT, 32'h0);
    rdchk(OFS_CURRENT_STEP, 32'h2);
    chk("pattern", 32'h5A5A, {16'h0, pat});
    req <= 3'b000;
    scans(4);
    rdchk(OFS_CURRENT_STEP, 32'h2);
    $display("test timed done");
    req <= 3'b010;
    scans(2);
    req <= 3'b000;
    scans(2);
    rdchk(OFS_CURRENT_STEP, 32'h3);
    chk("pattern", 32'h0, {16'h0, pat});
    $display("test jog done");
    xfer(1'b1, OFS_EVCFG_BASE + 8'h08, 32'h51);
    xfer(1'b1, OFS_LAST_STEP, 32'h4);
    xfer(1'b1, OFS_PATTERN_BASE + 8'h0C, 32'h0F0F);
    req <= 3'b100;
    scans(4);
    rdchk(OFS_CURRENT_STEP, 32'h3);
    inpts <= 16'h0020;
    scans(3);
    chk("complete", 32'h1, {31'h0, done});
    chk("pattern", 32'h0F0F, {16'h0, pat});
    rdchk(OFS_STATUS, 32'h1);
    req <= 3'b010;
    scans(3);
    rdchk(OFS_CURRENT_STEP, 32'h4);
    $display("test event done");
    xfer(1'b1, OFS_PRESET_STEP, 32'h3);
    req <= 3'b001;
    scans(2);
    chk("complete", 32'h0, {31'h0, done});
    rdchk(OFS_CURRENT_STEP, 32'h3);
    rdchk(OFS_STATUS, 32'h2);
    req <= 3'b000;
    scans(2);
    rdchk(OFS_PRESET_STEP, 32'h3);
    $display("test reset step done");
    xfer(1'b1, OFS_CURRENT_STEP, 32'd17);
    rdchk(OFS_CURRENT_STEP, 32'h3);
    xfer(1'b1, OFS_CURRENT_STEP, 32'h10);
    rdchk(OFS_CURRENT_STEP, 32'h10);
    rdchk(OFS_TICK_TIMER, 32'h0);
    xfer(1'b1, OFS_OUT_MASK, 32'h00FF);
    xfer(1'b1, OFS_PATTERN_BASE + 8'h3C, 32'hFFFF);
    // pattern lags the table write by one cycle
    @(posedge mclk_i);
    chk("pattern", 32'h00FF, {16'h0, pat});
    $display("test jump done");
    // step 16: timer and event, event from relay bit 3, limit 0
    xfer(1'b1, OFS_EVCFG_BASE + 8'h3C, 32'h3A);
    req <= 3'b100;
    scans(3);
    rdchk(OFS_CURRENT_STEP, 32'h10);
    rly <= 16'h0008;
    scans(3);
    chk("complete", 32'h1, {31'h0, done});
    $display("test relay done");
    close_out();
  end
endmodule : eds_sequencer_tb
